/* rtl/vic_core.sv */
// vic_core: request flags, masks, edge mode, status word enable and acknowledge
// arbitration for the cpu sequencer.
// assumes: core sequencer marks instruction ends and accepts ACK_REQ at an end.
`timescale 1ns/1ps
module vic_core
(
  // clock and reset
  input  wire logic                REF_CLK,
  input  wire logic                RESETN,
  // register access from the core
  input  wire vic_pkg::vic_bus_t   BUS,
  output logic [7:0]               RDATA,
  // sequencer
  input  wire vic_pkg::vic_seq_t   SEQ,
  input  wire logic                ACK_TAKEN,
  output vic_pkg::vic_ack_t        ACK,
  output logic [7:0]               STATUS_WORD,
  output logic [7:0]               STATUS_PUSH,
  // sources
  input  wire logic                EXT_IRQ_A,
  input  wire logic                EXT_IRQ_B,
  input  wire logic                WDOG_IRQ,
  input  wire logic                WDOG_MODE_NMI,
  input  wire logic [11:0]         SRC_EVENT
);
  import vic_pkg::*;

  typedef struct packed {
    logic [11:0] req;
    logic [11:0] mask;
    logic [7:0]  edge_mode;
    logic [7:0]  status;
    logic [7:0]  rdata;
    logic        defer;
    logic        late;
    logic        pend_nmi;
    vic_ack_t    ack;
    logic [7:0]  push;
  } vic_state_t;

  vic_state_t  st_q;
  vic_state_t  st_d;
  logic        hit_a;
  logic        hit_b;
  logic [11:0] set_vec;
  logic [11:0] elig;
  logic        any_elig;
  logic [3:0]  win;
  logic        flag_access;
  logic        ack_allowed;

  // ==========================================================
  // external edge detectors
  vic_edge_detect u_edge_a (
    .clk  (REF_CLK),
    .rst_n(RESETN),
    .pin  (EXT_IRQ_A),
    .mode (st_q.edge_mode[VIC_EDGE_A_LSB +: 2]),
    .hit  (hit_a)
  );

  vic_edge_detect u_edge_b (
    .clk  (REF_CLK),
    .rst_n(RESETN),
    .pin  (EXT_IRQ_B),
    .mode (st_q.edge_mode[VIC_EDGE_B_LSB +: 2]),
    .hit  (hit_b)
  );

  // ==========================================================
  // source events and fixed priority pick
  always_comb
  begin
    set_vec = SRC_EVENT;
    set_vec[VIC_SRC_WDOG]  = WDOG_IRQ & ~WDOG_MODE_NMI;
    set_vec[VIC_SRC_EXT_A] = SRC_EVENT[VIC_SRC_EXT_A] | hit_a;
    set_vec[VIC_SRC_EXT_B] = SRC_EVENT[VIC_SRC_EXT_B] | hit_b;
    elig     = st_q.req & ~st_q.mask;
    any_elig = (|elig) & st_q.status[VIC_IE_BIT];
    win      = 4'h0;
    for (int i = VIC_NSRC - 1; i >= 0; i--)
    begin
      if (elig[i])
        win = 4'(i);
    end
    flag_access = (BUS.wr | BUS.rd) &&
                  (BUS.addr == VIC_ADDR_REQ_LO || BUS.addr == VIC_ADDR_REQ_HI ||
                   BUS.addr == VIC_ADDR_MASK_LO || BUS.addr == VIC_ADDR_MASK_HI);
    ack_allowed = SEQ.instr_end & ~st_q.defer & ~st_q.late;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    st_d = st_q;
    // register writes
    if (BUS.wr)
    begin
      case (BUS.addr)
        VIC_ADDR_REQ_LO:  st_d.req[7:0]   = BUS.wdata;
        VIC_ADDR_REQ_HI:  st_d.req[11:8]  = BUS.wdata[3:0];
        VIC_ADDR_MASK_LO: st_d.mask[7:0]  = BUS.wdata;
        VIC_ADDR_MASK_HI: st_d.mask[11:8] = BUS.wdata[3:0];
        VIC_ADDR_EDGE:    st_d.edge_mode  = BUS.wdata & VIC_EDGE_WMASK;
        default:          st_d.edge_mode  = st_q.edge_mode;
      endcase
    end
    // status word: byte writes, restore by return or pop, enable instructions
    if (SEQ.status_wr)
      st_d.status = SEQ.status_wdata;
    if (SEQ.ie_set)
      st_d.status[VIC_IE_BIT] = 1'b1;
    if (SEQ.ie_clr)
      st_d.status[VIC_IE_BIT] = 1'b0;
    // read mux
    st_d.rdata = 8'h00;
    if (BUS.rd)
    begin
      case (BUS.addr)
        VIC_ADDR_REQ_LO:  st_d.rdata = st_q.req[7:0];
        VIC_ADDR_REQ_HI:  st_d.rdata = {4'h0, st_q.req[11:8]};
        VIC_ADDR_MASK_LO: st_d.rdata = {st_q.mask[7:1],
                                        st_q.mask[0] & ~WDOG_MODE_NMI};
        VIC_ADDR_MASK_HI: st_d.rdata = {4'hF, st_q.mask[11:8]};
        VIC_ADDR_EDGE:    st_d.rdata = st_q.edge_mode;
        default:          st_d.rdata = 8'h00;
      endcase
    end
    // deferral: flag register access holds off acks past the next instruction
    if (flag_access)
      st_d.defer = 1'b1;
    else if (SEQ.instr_end && !st_q.defer)
      st_d.defer = 1'b0;
    else if (SEQ.instr_end)
      st_d.defer = 1'b0;
    // a flag set in the last clock waits two further instructions
    if (SEQ.instr_end)
      st_d.late = SEQ.last_clk & ((|set_vec) | (WDOG_IRQ & WDOG_MODE_NMI));
    // non-maskable pending, accepted even while disabled or in service
    if (WDOG_IRQ & WDOG_MODE_NMI)
      st_d.pend_nmi = 1'b1;
    // present acknowledge at an allowed instruction end
    if (ACK_TAKEN && st_q.ack.req)
    begin
      st_d.ack.req = 1'b0;
      st_d.status[VIC_IE_BIT] = 1'b0;
      if (st_q.ack.nmi)
        st_d.pend_nmi = WDOG_IRQ & WDOG_MODE_NMI;
      else
        st_d.req[st_q.ack.idx] = 1'b0;
    end
    else if (!st_q.ack.req && ack_allowed)
    begin
      if (st_q.pend_nmi)
      begin
        st_d.ack.req    = 1'b1;
        st_d.ack.nmi    = 1'b1;
        st_d.ack.idx    = 4'h0;
        st_d.ack.vector = VIC_VEC_NMI;
        st_d.push       = st_q.status;
      end
      else if (any_elig)
      begin
        st_d.ack.req    = 1'b1;
        st_d.ack.nmi    = 1'b0;
        st_d.ack.idx    = win;
        st_d.ack.vector = VIC_VEC_BASE + {11'h000, win, 1'b0};  // two bytes per entry, index 0 shares the base
        st_d.push       = st_q.status;
      end
    end
    // hardware set wins over software clear and acknowledge clear
    st_d.req = st_d.req | set_vec;
    // bits 5, 3 and 2 always read zero, bit 1 always reads one
    st_d.status = (st_d.status & VIC_STATUS_ZEROS) | VIC_STATUS_ONES;
  end

  // ==========================================================
  // state register
  always_ff @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      st_q           <= '0;
      st_q.req       <= VIC_REQ_RST;
      st_q.mask      <= VIC_MASK_RST;
      st_q.edge_mode <= VIC_EDGE_RST;
      st_q.status    <= VIC_STATUS_RST;
    end
    else
      st_q <= st_d;
  end

  // ==========================================================
  // outputs straight from the state register
  always_comb
  begin
    RDATA       = st_q.rdata;
    ACK         = st_q.ack;
    STATUS_WORD = st_q.status;
    STATUS_PUSH = st_q.push;
  end

endmodule

/* inc/vic_pkg.sv */
// vic_pkg: constants and carrier types for the vectored interrupt control block.
// assumes: one cpu clock, synchronous active-low reset, core sequencer on the far side.
//
// Overview of operation
// - in either watchdog mode the watchdog mask flag reads back undefined (we return zero in non-maskable mode, the stored flag in maskable mode).
// - edge mode register is 8 bits, byte written, reset to 00H.
// - bits 5:4 pick external B edge: falling, rising, both; 10 prohibited.
// - bits 3:2 pick external A edge: falling, rising, both; 10 prohibited.
// - status word is 8 bits, enable at bit 7, bit 1 reads one, reset 02H.
// - acceptance pushes status word and clears enable; return or pop restores it.
// - non-maskable request is taken even when disabled and beats every maskable one.
// - non-maskable acceptance pushes status then pc, clears enable, loads vector.
// - a second non-maskable request preempts a running non-maskable service.
// - maskable request taken only when flag is one, mask zero, enable one.
// - maskable request to service start takes 9 to 19 cpu clocks.
// - simultaneous eligible maskable requests go by fixed priority, others stay pending.
// - a request not yet acceptable stays pending until it can be accepted.
// - flag rising before the second-to-last clock is acknowledged after that instruction.
// - flag rising in the final clock waits one further instruction (we wait two further instructions).
// - accesses to request or mask registers defer all acknowledgement past the next instruction.
// - nesting only if the service routine sets the enable again, else waits.
// - maskable acceptance pushes status then pc, clears enable, loads own vector.
// - priority 0 watchdog down to 11 watch interval, fixed order.
// - request flags set by source or software, cleared on acknowledge and reset.
// - reset sets mask registers to all ones; zero enables servicing.
// - watchdog source routes to non-maskable or maskable index 0 by mode.
package vic_pkg;

  // ==========================================================
  // register addresses and reset values
  localparam logic [15:0] VIC_ADDR_REQ_LO  = 16'hFFE0;
  localparam logic [15:0] VIC_ADDR_REQ_HI  = 16'hFFE1;
  localparam logic [15:0] VIC_ADDR_MASK_LO = 16'hFFE4;
  localparam logic [15:0] VIC_ADDR_MASK_HI = 16'hFFE5;
  localparam logic [15:0] VIC_ADDR_EDGE    = 16'hFFEC;
  localparam logic [7:0]  VIC_EDGE_RST     = 8'h00;
  localparam logic [7:0]  VIC_EDGE_WMASK   = 8'h3C;
  localparam logic [7:0]  VIC_STATUS_RST   = 8'h02;
  localparam logic [7:0]  VIC_STATUS_ONES  = 8'h02;
  localparam logic [7:0]  VIC_STATUS_ZEROS = 8'hD3;
  localparam logic [11:0] VIC_REQ_RST      = 12'h000;
  localparam logic [11:0] VIC_MASK_RST     = 12'hFFF;
  localparam int          VIC_NSRC         = 12;

  // ==========================================================
  // field positions
  localparam int VIC_IE_BIT     = 7;
  localparam int VIC_EDGE_B_LSB = 4;
  localparam int VIC_EDGE_A_LSB = 2;
  localparam int VIC_SRC_WDOG   = 0;
  localparam int VIC_SRC_EXT_A  = 1;
  localparam int VIC_SRC_EXT_B  = 2;

  // ==========================================================
  // vectors and edge codes
  localparam logic [15:0] VIC_VEC_NMI  = 16'h0004;
  localparam logic [15:0] VIC_VEC_BASE = 16'h0004;
  localparam logic [1:0]  VIC_EDGE_FALL = 2'h0;
  localparam logic [1:0]  VIC_EDGE_RISE = 2'h1;
  localparam logic [1:0]  VIC_EDGE_BOTH = 2'h3;

  // ==========================================================
  // timing: acknowledgement latency bounds in cpu clocks, 40 MHz
  localparam int VIC_CLK_NS      = 25;
  localparam int VIC_LAT_MIN_CLK = 9;
  localparam int VIC_LAT_MAX_CLK = 19;

  // register bus request from the core
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } vic_bus_t;

  // sequencer status toward the block
  typedef struct packed {
    logic       instr_end;
    logic       last_clk;
    logic       status_wr;
    logic [7:0] status_wdata;
    logic       ie_set;
    logic       ie_clr;
  } vic_seq_t;

  // acknowledge presented to the core
  typedef struct packed {
    logic        req;
    logic        nmi;
    logic [3:0]  idx;
    logic [15:0] vector;
  } vic_ack_t;

endpackage

/* rtl/vic_edge_detect.sv */
// vic_edge_detect: synchronises one external pin and flags the selected edge.
// assumes: pin is asynchronous to the cpu clock.
`timescale 1ns/1ps
module vic_edge_detect
  import vic_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // pin and mode
  input  wire logic       pin,
  input  wire logic [1:0] mode,
  // event
  output logic            hit
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } vic_sync_t;

  vic_sync_t st_q;
  vic_sync_t st_d;
  logic      rise;
  logic      fall;

  // two flops then an edge history flop
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // edge decode, prohibited code 10 gives no event
  always_comb
  begin
    rise = st_q.s2 & ~st_q.s3;
    fall = ~st_q.s2 & st_q.s3;
    case (mode)
      VIC_EDGE_FALL: hit = fall;
      VIC_EDGE_RISE: hit = rise;
      VIC_EDGE_BOTH: hit = rise | fall;
      default:       hit = 1'b0;
    endcase
  end

endmodule

/* test/vic_core_chk.sv */
// vic_core_chk: port assertions for vic_core.
// assumes: bound into vic_core; one clock, sync active-low reset.
`timescale 1ns/1ps
module vic_core_chk
(
  // clock and reset
  input logic              REF_CLK,
  input logic              RESETN,
  // bus and sequencer
  input vic_pkg::vic_bus_t BUS,
  input logic [7:0]        RDATA,
  input vic_pkg::vic_seq_t SEQ,
  input logic              ACK_TAKEN,
  // acknowledge and status
  input vic_pkg::vic_ack_t ACK,
  input logic [7:0]        STATUS_WORD
);
  import vic_pkg::*;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // ==========
  // assertions
  rst_state_a: assert property ($rose(RESETN) |-> STATUS_WORD == 8'h02 && !ACK.req)
    else $error("status or ack wrong after reset");
  bit_one_a: assert property (STATUS_WORD[1])
    else $error("status bit 1 not one");
  zero_bits_a: assert property ((STATUS_WORD & 8'h2C) == 8'h00)
    else $error("status fixed zero bit set");
  ack_hold_a: assert property (ACK.req && !ACK_TAKEN |=> ACK.req && $stable(ACK.vector))
    else $error("ack dropped before taken");
  ack_clear_a: assert property (ACK.req && ACK_TAKEN |=> !ACK.req && !STATUS_WORD[7])
    else $error("ack or enable not cleared at accept");
  vec_map_a: assert property (ACK.req |-> ACK.vector == (ACK.nmi ? 16'h0004 : 16'h0004 + {11'h0, ACK.idx, 1'b0}))
    else $error("vector does not match source");
  ack_at_end_a: assert property ($rose(ACK.req) |-> $past(SEQ.instr_end))
    else $error("ack not at instruction end");
  mask_gate_a: assert property ($rose(ACK.req) && !ACK.nmi |-> $past(STATUS_WORD[7]))
    else $error("maskable ack while disabled");
  rd_idle_a: assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
    else $error("read data without read");
  // main scenarios
  cov_nmi: cover property (ACK.req && ACK.nmi && ACK_TAKEN);
  cov_mask: cover property (ACK.req && !ACK.nmi && ACK_TAKEN);
  cov_read: cover property (BUS.rd ##1 RDATA != 8'h00);
endmodule

bind vic_core vic_core_chk chk_u (.REF_CLK, .RESETN, .BUS, .RDATA, .SEQ, .ACK_TAKEN, .ACK, .STATUS_WORD);

/* test/vic_seq_model.sv */
// vic_seq_model: core sequencer model facing vic_core.
// assumes: instructions of ilen clocks, service starts at an instruction end.
`timescale 1ns/1ps
module vic_seq_model
(
  // clock and reset
  input  logic              clk,
  input  logic              rst_n,
  // bench control
  input  logic [3:0]        ilen,
  input  logic              ie_on,
  input  logic              ie_off,
  input  logic [8:0]        st_ld,
  // block side
  input  vic_pkg::vic_ack_t ack,
  output vic_pkg::vic_seq_t seq,
  output logic              taken
);
  import vic_pkg::*;
  logic [3:0] cnt_q;
  logic       ie_set_q;
  logic       ie_clr_q;
  logic [8:0] ld_q;
  // instruction end pulse, also the final clock of it; status loads and enable instructions
  always_comb
  begin
    seq              = '0;
    seq.instr_end    = (cnt_q == ilen - 4'h1);
    seq.last_clk     = seq.instr_end;
    seq.status_wr    = ld_q[8];
    seq.status_wdata = ld_q[7:0];
    seq.ie_set       = ie_set_q;
    seq.ie_clr       = ie_clr_q;
  end
  // clock count, enable instruction and service start
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q    <= 4'h0;
      taken    <= 1'b0;
      ie_set_q <= 1'b0;
      ie_clr_q <= 1'b0;
      ld_q     <= 9'h000;
    end
    else
    begin
      cnt_q    <= seq.instr_end ? 4'h0 : cnt_q + 4'h1;
      ie_set_q <= ie_on;
      ie_clr_q <= ie_off;
      ld_q     <= st_ld;
      taken    <= ack.req && !taken && seq.instr_end;
    end
  end
endmodule

/* test/tb_vic_core.sv */
// tb_vic_core: self-checking bench for vic_core.
// assumes: vic_seq_model as far side, checker bound by its own file.
`timescale 1ns/1ps
module tb_vic_core;
  import vic_pkg::*;
  logic        REF_CLK = 0;
  logic        RESETN = 0;
  vic_bus_t    bus = '0;
  vic_seq_t    seq;
  vic_ack_t    ack;
  logic [7:0]  rdata, sw, push;
  logic        taken, hit;
  logic        ext_a = 1, ext_b = 1, wdog = 0, wmode = 1, ie_on = 0, ie_off = 0;
  logic [8:0]  st_ld = '0;
  logic [11:0] src = '0;
  logic [3:0]  ilen = 4'h4;
  logic [1:0]  codes[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int          num_errors = 0, total_checks = 0, seed = 94, cyc = 0, a;
  int          exp_q[$];
  // ==========
  // clock, design and far side
  always #12.5 REF_CLK = ~REF_CLK;
  vic_core dut_u (.REF_CLK(REF_CLK), .RESETN(RESETN), .BUS(bus), .RDATA(rdata), .SEQ(seq),
    .ACK_TAKEN(taken), .ACK(ack), .STATUS_WORD(sw), .STATUS_PUSH(push), .EXT_IRQ_A(ext_a),
    .EXT_IRQ_B(ext_b), .WDOG_IRQ(wdog), .WDOG_MODE_NMI(wmode), .SRC_EVENT(src));
  vic_seq_model core_u (.clk(REF_CLK), .rst_n(RESETN), .ilen(ilen), .ie_on(ie_on), .ie_off(ie_off),
    .st_ld(st_ld), .ack(ack), .seq(seq), .taken(taken));
  // ==========
  // shared tasks
  task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] ad, logic [7:0] d);
    @(negedge REF_CLK) bus = '{1'b1, 1'b0, ad, d};
    @(negedge REF_CLK) bus = '0;
  endtask
  task automatic rd(logic [15:0] ad, logic [7:0] e, string n);
    @(negedge REF_CLK) bus = '{1'b0, 1'b1, ad, 8'h00};
    @(negedge REF_CLK) bus = '0;
    check(n, rdata, e);
  endtask
  // raise an enable instruction and let service run
  task automatic enable_wait(int e);
    if (e >= 0)
      exp_q.push_back(e);
    @(negedge REF_CLK) ie_on = 1;
    @(negedge REF_CLK) ie_on = 0;
    repeat (40) @(negedge REF_CLK);
    check("pending acks", exp_q.size(), 0);
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // every service start must match the oldest expected source
  always @(negedge REF_CLK)
    if (taken && ack.req)
    begin
      check("ack source", ack.nmi ? 16 : ack.idx, exp_q.size() ? exp_q.pop_front() : 99);
      check("pushed status", push, ack.nmi ? 16'h0002 : 16'h0082);
    end
  // hang guard
  always @(posedge REF_CLK)
    if (++cyc > 20000)
    begin
      num_errors++;
      give_verdict();
    end
  // ==========
  // main sequence
  initial
  begin
    repeat (2) @(negedge REF_CLK);
    RESETN = 1;
    check("status", sw, 8'h02);
    rd(VIC_ADDR_EDGE, 8'h00, "edge");
    rd(VIC_ADDR_REQ_LO, 8'h00, "req lo");
    rd(VIC_ADDR_MASK_LO, 8'hFE, "mask lo");
    rd(VIC_ADDR_MASK_HI, 8'hFF, "mask hi");
    foreach (codes[i])
    begin
      wr(VIC_ADDR_EDGE, {2'b00, codes[i], codes[i], 2'b00});
      rd(VIC_ADDR_EDGE, {2'b00, codes[i], codes[i], 2'b00}, "edge");
      for (int lv = 0; lv < 2; lv++)
      begin
        // pins toggle only while their mask flags are still set
        @(negedge REF_CLK) {ext_a, ext_b} = {2{lv[0]}};
        repeat (6) @(negedge REF_CLK);
        hit = codes[i] == 2'h3 || codes[i] == lv;
        rd(VIC_ADDR_REQ_LO, {5'h0, hit, hit, 1'b0}, "pin flags");
        wr(VIC_ADDR_REQ_LO, 8'h00);
      end
    end
    wr(VIC_ADDR_MASK_LO, 8'h00);
    wr(VIC_ADDR_MASK_HI, 8'h00);
    // two sources at once while disabled, then one per enable
    a = 3 + ($unsigned($random(seed)) % 8);
    @(negedge REF_CLK) src = 12'h003 << a;
    @(negedge REF_CLK) src = '0;
    repeat (40) @(negedge REF_CLK);
    enable_wait(a);
    ilen = 4'h7;
    enable_wait(a + 1);
    // masked source waits until unmasked
    wr(VIC_ADDR_MASK_LO, 8'h08);
    @(negedge REF_CLK) src = 12'h008;
    @(negedge REF_CLK) src = '0;
    enable_wait(-1);
    exp_q.push_back(3);
    wr(VIC_ADDR_MASK_LO, 8'h00);
    repeat (40) @(negedge REF_CLK);
    check("masked ack", exp_q.size(), 0);
    // watchdog as non-maskable with enable off, then as source 0
    exp_q.push_back(16);
    @(negedge REF_CLK) wdog = 1;
    @(negedge REF_CLK) wdog = 0;
    repeat (40) @(negedge REF_CLK);
    check("nmi ack", exp_q.size(), 0);
    wmode = 0;
    @(negedge REF_CLK) wdog = 1;
    @(negedge REF_CLK) wdog = 0;
    enable_wait(0);
    // status restore by the sequencer, fixed bits forced, then a disable instruction
    @(negedge REF_CLK) st_ld = 9'h1FF;
    @(negedge REF_CLK) st_ld = '0;
    repeat (2) @(negedge REF_CLK);
    check("status load", sw, 8'hD3);
    @(negedge REF_CLK) ie_off = 1;
    @(negedge REF_CLK) ie_off = 0;
    repeat (2) @(negedge REF_CLK);
    check("status off", sw, 8'h53);
    give_verdict();
  end
endmodule
